// [core/sls_sched.sv]
`timescale 1ns/1ps
`default_nettype none
module sls_sched
    import sls_pkg::*;
#(
    parameter int TRCD = 3,
    parameter int TRP  = 3
) (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   ce,
    // Static configuration
    input  wire sls_map_t               cfg_map,
    input  wire logic [LAT_W-1:0]       cfg_al,
    input  wire logic [LAT_W-1:0]       cfg_cl,
    input  wire logic                   cfg_quarter,
    input  wire logic                   cfg_lock,
    // User request
    input  wire logic                   req_vld,
    input  wire logic                   req_wr,
    input  wire logic [ADDR_W-1:0]      req_addr,
    output logic                        req_rdy,
    // Memory command side
    output sls_mcmd_t                   mem_cmd,
    output logic                        wr_data_en,
    input  wire logic                   rd_data_vld_phy,
    output logic                        rd_data_vld,
    output logic [LAT_W-1:0]            rd_lat_tot,
    output logic [LAT_W-1:0]            ac_lat_tot,
    output logic                        cfg_err
);
    // ------------------------------------------------------------
    // Address mapping
    // ------------------------------------------------------------
    function automatic sls_maddr_t map_addr(input sls_map_t m, input logic [ADDR_W-1:0] a);
        sls_maddr_t r;
        r = '0;
        r.col = a[COL_W-1:0];
        case (m)
            SLS_MAP_CRBC: begin
                r.bank = a[COL_W +: BANK_W];
                r.row  = a[COL_W+BANK_W +: ROW_W];
                r.cs   = a[COL_W+BANK_W+ROW_W +: CS_W];
            end
            SLS_MAP_RCBC: begin
                r.bank = a[COL_W +: BANK_W];
                r.cs   = a[COL_W+BANK_W +: CS_W];
                r.row  = a[COL_W+BANK_W+CS_W +: ROW_W];
            end
            default: begin
                r.row  = a[COL_W +: ROW_W];
                r.bank = a[COL_W+ROW_W +: BANK_W];
                r.cs   = a[COL_W+ROW_W+BANK_W +: CS_W];
            end
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // Static configuration capture
    // ------------------------------------------------------------
    // Settings are sampled while unlocked and frozen once traffic may run
    sls_map_t         map_r, map_nxt;
    logic [LAT_W-1:0] al_r, al_nxt, cl_r, cl_nxt;
    logic             qtr_r, qtr_nxt;
    logic             err_r, err_nxt;

    always_comb begin
        map_nxt = map_r;
        al_nxt  = al_r;
        cl_nxt  = cl_r;
        qtr_nxt = qtr_r;
        err_nxt = err_r;
        if (!cfg_lock) begin
            map_nxt = cfg_map;
            al_nxt  = cfg_al;
            cl_nxt  = cfg_cl;
            qtr_nxt = cfg_quarter;
            // One spare bit keeps a large AL plus CL from wrapping into range
            err_nxt = (({1'b0, cfg_al} + {1'b0, cfg_cl}) < (LAT_W+1)'(MEM_RL_MIN))
                   || (({1'b0, cfg_al} + {1'b0, cfg_cl}) > (LAT_W+1)'(MEM_RL_MAX));
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            map_r <= SLS_MAP_CBRC;
            al_r  <= '0;
            cl_r  <= LAT_W'(MEM_RL_MIN);
            qtr_r <= 1'b0;
            err_r <= 1'b0;
        end else if (ce) begin
            map_r <= map_nxt;
            al_r  <= al_nxt;
            cl_r  <= cl_nxt;
            qtr_r <= qtr_nxt;
            err_r <= err_nxt;
        end
    end

    // ------------------------------------------------------------
    // Bank tracking and command issue
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SLS_ST_IDLE = 2'b00,
        SLS_ST_PRE  = 2'b01,
        SLS_ST_ACT  = 2'b10,
        SLS_ST_COL  = 2'b11
    } sls_st_t;

    sls_st_t                 st_r, st_nxt;
    sls_maddr_t              cur_r, cur_nxt;
    logic                    wr_r, wr_nxt;
    logic [NBANK-1:0]        open_r, open_nxt;
    logic [ROW_W-1:0]        orow_r [NBANK];
    logic [ROW_W-1:0]        orow_nxt [NBANK];
    logic [CNT_W-1:0]        wait_r [NBANK];
    logic [CNT_W-1:0]        wait_nxt [NBANK];
    sls_mcmd_t               cmd_r, cmd_nxt;
    logic                    rdy_r, rdy_nxt;
    logic                    wpulse, rpulse;
    sls_maddr_t              in_map;
    logic                    col_ok;
    logic [LAT_W-1:0]        al_core;

    assign in_map = map_addr(map_r, req_addr);
    // AL counts full-rate cycles, bank timers core cycles; rounding down stays safe
    assign al_core = al_r / LAT_W'(FR_PER_CORE);
    // Column may go before tRCD only when AL covers the remainder
    assign col_ok = (wait_r[cur_r.bank] == '0)
                 || (al_core <= LAT_W'(TRCD) && {1'b0, wait_r[cur_r.bank]} <= al_core);

    always_comb begin
        st_nxt   = st_r;
        cur_nxt  = cur_r;
        wr_nxt   = wr_r;
        open_nxt = open_r;
        cmd_nxt  = '0;
        rdy_nxt  = 1'b0;
        wpulse   = 1'b0;
        rpulse   = 1'b0;
        for (int b = 0; b < NBANK; b++) begin
            orow_nxt[b] = orow_r[b];
            // Each bank times out independently so others keep working
            wait_nxt[b] = (wait_r[b] != '0) ? wait_r[b] - CNT_W'(1) : '0;
        end
        case (st_r)
            SLS_ST_IDLE: begin
                // Follows the next error value so ready never overlaps a fresh error
                rdy_nxt = !err_nxt;
                if (rdy_r && req_vld) begin
                    cur_nxt = in_map;
                    wr_nxt  = req_wr;
                    rdy_nxt = 1'b0;
                    if (open_r[in_map.bank] && orow_r[in_map.bank] == in_map.row) begin
                        st_nxt = SLS_ST_COL;
                    end else if (open_r[in_map.bank]) begin
                        st_nxt = SLS_ST_PRE;
                    end else begin
                        st_nxt = SLS_ST_ACT;
                    end
                end
            end
            SLS_ST_PRE: begin
                if (wait_r[cur_r.bank] == '0) begin
                    cmd_nxt = '{1'b1, SLS_CMD_PRE, cur_r};
                    open_nxt[cur_r.bank] = 1'b0;
                    wait_nxt[cur_r.bank] = CNT_W'(TRP);
                    st_nxt = SLS_ST_ACT;
                end
            end
            SLS_ST_ACT: begin
                if (wait_r[cur_r.bank] == '0) begin
                    cmd_nxt = '{1'b1, SLS_CMD_ACT, cur_r};
                    open_nxt[cur_r.bank] = 1'b1;
                    orow_nxt[cur_r.bank] = cur_r.row;
                    wait_nxt[cur_r.bank] = CNT_W'(TRCD);
                    st_nxt = SLS_ST_COL;
                end
            end
            SLS_ST_COL: begin
                if (col_ok) begin
                    cmd_nxt = '{1'b1, wr_r ? SLS_CMD_WR : SLS_CMD_RD, cur_r};
                    wpulse  = wr_r;
                    rpulse  = !wr_r;
                    wait_nxt[cur_r.bank] = '0;
                    // Ready again at once so the next bank goes next cycle
                    rdy_nxt = !err_nxt;
                    st_nxt  = SLS_ST_IDLE;
                end
            end
            default: begin
                st_nxt = SLS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r   <= SLS_ST_IDLE;
            cur_r  <= '0;
            wr_r   <= 1'b0;
            open_r <= '0;
            cmd_r  <= '0;
            rdy_r  <= 1'b0;
            for (int b = 0; b < NBANK; b++) begin
                orow_r[b] <= '0;
                wait_r[b] <= '0;
            end
        end else if (ce) begin
            st_r   <= st_nxt;
            cur_r  <= cur_nxt;
            wr_r   <= wr_nxt;
            open_r <= open_nxt;
            cmd_r  <= cmd_nxt;
            rdy_r  <= rdy_nxt;
            for (int b = 0; b < NBANK; b++) begin
                orow_r[b] <= orow_nxt[b];
                wait_r[b] <= wait_nxt[b];
            end
        end
    end

    // ------------------------------------------------------------
    // Latency figures and data timing
    // ------------------------------------------------------------
    // Counted in full-rate cycles; core delays are half of these
    logic [LAT_W-1:0] acl_r, acl_nxt, rtl_r, rtl_nxt;
    logic [CNT_W-1:0] wl_dly, rl_dly;
    logic             wde, rdv;
    logic             wde_r, rdv_r;

    always_comb begin
        if (qtr_r) begin
            acl_nxt = LAT_W'((wr_r ? CTL_AC_QTR_WR : CTL_AC_QTR_RD) + PHY_AC_LAT);
        end else begin
            acl_nxt = LAT_W'((wr_r ? CTL_AC_HALF_WR : CTL_AC_HALF_RD) + PHY_AC_LAT);
        end
        rtl_nxt = LAT_W'(PHY_RD_RET + (qtr_r ? CTL_RD_RET_QTR : CTL_RD_RET_HALF));
    end

    // Write latency AL+CL-1 full-rate cycles read latency AL+CL
    assign wl_dly = CNT_W'((al_r + cl_r - LAT_W'(1)) / LAT_W'(FR_PER_CORE));
    assign rl_dly = CNT_W'((al_r + cl_r) / LAT_W'(FR_PER_CORE));

    sls_delay #(.DEPTH(32)) u_wdly (
        .clk  (clk),
        .nrst (nrst),
        .ce   (ce),
        .din  (wpulse),
        .dly  (wl_dly),
        .dout (wde)
    );

    // Read window opened at AL+CL qualifies what the PHY hands back
    sls_delay #(.DEPTH(32)) u_rdly (
        .clk  (clk),
        .nrst (nrst),
        .ce   (ce),
        .din  (rpulse),
        .dly  (rl_dly),
        .dout (rdv)
    );

    always_ff @(posedge clk) begin
        if (!nrst) begin
            acl_r <= '0;
            rtl_r <= '0;
            wde_r <= 1'b0;
            rdv_r <= 1'b0;
        end else if (ce) begin
            acl_r <= acl_nxt;
            rtl_r <= rtl_nxt;
            wde_r <= wde;
            rdv_r <= rdv && rd_data_vld_phy;
        end
    end

    assign req_rdy     = rdy_r;
    assign mem_cmd     = cmd_r;
    assign wr_data_en  = wde_r;
    assign rd_data_vld = rdv_r;
    assign ac_lat_tot  = acl_r;
    assign rd_lat_tot  = rtl_r;
    assign cfg_err     = err_r;
endmodule
`default_nettype wire

// [inc/sls_pkg.sv]
`default_nettype none
package sls_pkg;
    // Latencies in full-rate memory clock cycles
    localparam int CTL_AC_HALF_WR  = 12;
    localparam int CTL_AC_HALF_RD  = 8;
    localparam int CTL_AC_QTR_WR   = 14;
    localparam int CTL_AC_QTR_RD   = 10;
    localparam int PHY_AC_LAT      = 2;
    localparam int PHY_RD_RET      = 6;
    localparam int CTL_RD_RET_HALF = 8;
    localparam int CTL_RD_RET_QTR  = 14;
    localparam int MEM_RL_MIN      = 3;
    localparam int MEM_RL_MAX      = 23;
    // Core runs at half rate: two full-rate cycles per core clock
    localparam int FR_PER_CORE     = 2;
    localparam int LAT_W           = 6;
    localparam int CNT_W           = 5;

    // Field widths
    localparam int COL_W  = 10;
    localparam int BANK_W = 2;
    localparam int ROW_W  = 14;
    localparam int CS_W   = 1;
    localparam int ADDR_W = COL_W + BANK_W + ROW_W + CS_W;
    localparam int NBANK  = 1 << BANK_W;

    typedef enum logic [1:0] {
        SLS_MAP_CBRC = 2'h0,
        SLS_MAP_CRBC = 2'h1,
        SLS_MAP_RCBC = 2'h2
    } sls_map_t;

    typedef enum logic [2:0] {
        SLS_CMD_NOP = 3'h0,
        SLS_CMD_ACT = 3'h1,
        SLS_CMD_RD  = 3'h2,
        SLS_CMD_WR  = 3'h3,
        SLS_CMD_PRE = 3'h4
    } sls_cmd_t;

    typedef struct packed {
        logic [CS_W-1:0]   cs;
        logic [ROW_W-1:0]  row;
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0]  col;
    } sls_maddr_t;

    typedef struct packed {
        logic              vld;
        sls_cmd_t          cmd;
        sls_maddr_t        addr;
    } sls_mcmd_t;
endpackage
`default_nettype wire

// [core/sls_delay.sv]
`timescale 1ns/1ps
`default_nettype none
// Programmable delay line in core cycles; one tap per core cycle.
module sls_delay
    import sls_pkg::*;
#(
    parameter int DEPTH = 32
) (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   ce,
    input  wire logic                   din,
    input  wire logic [CNT_W-1:0]       dly,
    output logic                        dout
);
    logic [DEPTH-1:0] sr_r;
    logic [DEPTH-1:0] sr_nxt;

    always_comb begin
        sr_nxt = {sr_r[DEPTH-2:0], din};
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sr_r <= '0;
        end else if (ce) begin
            sr_r <= sr_nxt;
        end
    end

    // Delay of 0 is not meaningful for a registered stage; it takes the first tap, sr_r[0]
    always_comb begin
        dout = (dly == '0) ? sr_r[0] : sr_r[dly];
    end
endmodule
`default_nettype wire

// [bench/sls_sched_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module sls_sched_asserts
    import sls_pkg::*;
#(
    parameter int TRCD = 3
) (
    input wire logic             clk,
    input wire logic             nrst,
    input wire logic [LAT_W-1:0] cfg_al,
    input wire logic [LAT_W-1:0] cfg_cl,
    input wire logic             cfg_quarter,
    input wire logic             cfg_lock,
    input wire logic             req_vld,
    input wire logic             req_rdy,
    input wire sls_mcmd_t        mem_cmd,
    input wire logic             wr_data_en,
    input wire logic             rd_data_vld_phy,
    input wire logic             rd_data_vld,
    input wire logic [LAT_W-1:0] rd_lat_tot,
    input wire logic             cfg_err
);
    // ----
    // Checks
    // ----
    localparam int COL_MAX = TRCD + 1;
    logic [LAT_W:0] lat_sum;
    assign lat_sum = {1'b0, cfg_al} + {1'b0, cfg_cl};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_err_blocks: assert property (cfg_err |-> !req_rdy)
        else $error("ready while config error");
    // Two locked cycles let the captured settings reach the flag
    a_err_range: assert property ($past(nrst, 2) && cfg_lock && $past(cfg_lock, 2)
        |-> cfg_err == (lat_sum < MEM_RL_MIN || lat_sum > MEM_RL_MAX))
        else $error("config error flag wrong");
    a_take_drop: assert property (req_vld && req_rdy |=> !req_rdy)
        else $error("ready held after take");
    a_take_cmd: assert property (req_vld && req_rdy |-> ##[1:3] mem_cmd.vld)
        else $error("no command after take");
    a_act_col: assert property (mem_cmd.vld && mem_cmd.cmd == SLS_CMD_ACT |->
        ##[1:COL_MAX] mem_cmd.vld && mem_cmd.cmd inside {SLS_CMD_RD, SLS_CMD_WR})
        else $error("column late after activate");
    a_wr_slot: assert property (mem_cmd.vld && mem_cmd.cmd == SLS_CMD_WR |->
        ##[1:14] wr_data_en)
        else $error("write slot missing");
    a_rd_gate: assert property (rd_data_vld |-> $past(rd_data_vld_phy))
        else $error("read valid without phy valid");
    a_rd_lat: assert property (rd_data_vld && cfg_lock |-> rd_lat_tot ==
        LAT_W'(PHY_RD_RET + (cfg_quarter ? CTL_RD_RET_QTR : CTL_RD_RET_HALF)))
        else $error("read return latency wrong");
endmodule
bind sls_sched sls_sched_asserts #(.TRCD(TRCD)) i_chk (.clk(clk), .nrst(nrst),
    .cfg_al(cfg_al), .cfg_cl(cfg_cl), .cfg_quarter(cfg_quarter), .cfg_lock(cfg_lock),
    .req_vld(req_vld), .req_rdy(req_rdy), .mem_cmd(mem_cmd), .wr_data_en(wr_data_en),
    .rd_data_vld_phy(rd_data_vld_phy), .rd_data_vld(rd_data_vld),
    .rd_lat_tot(rd_lat_tot), .cfg_err(cfg_err));
`default_nettype wire

// [bench/sls_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sls_mem_model
    import sls_pkg::*;
(
    input wire logic             clk,
    input wire logic             nrst,
    input wire sls_mcmd_t        mem_cmd,
    input wire logic [LAT_W-1:0] cfg_al,
    input wire logic [LAT_W-1:0] cfg_cl,
    output logic                 rd_data_vld_phy
);
    // ----
    // Read return
    // ----
    logic [31:0] sr_r;
    logic [31:0] sr_nxt;
    int          d;
    // Column command is held AL, then data follows CL later; the command
    // reaches us a cycle after the scheduler starts its count, hence one less
    always_comb begin
        sr_nxt = {sr_r[30:0], mem_cmd.vld && mem_cmd.cmd == SLS_CMD_RD};
        d = (int'(cfg_al) + int'(cfg_cl)) / FR_PER_CORE;
        d = (d > 0) ? d - 1 : 0;
    end
    always_ff @(posedge clk) begin
        sr_r <= nrst ? sr_nxt : '0;
    end
    // Two-cycle burst; low outside it, no stale level
    assign rd_data_vld_phy = sr_r[d] | sr_r[d+1];
endmodule
`default_nettype wire

// [bench/tb_sdram_latency_and_interleave_scheduler.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin n_errors++; \
    $display("MISMATCH %s exp %0h seen %0h", n, e, s); end end
module tb_sdram_latency_and_interleave_scheduler
    import sls_pkg::*;
;
    localparam int TRCD_TB = 3;
    logic              clk = 1'b0;
    logic              nrst = 1'b0;
    sls_map_t          cfg_map = SLS_MAP_CBRC;
    logic [LAT_W-1:0]  cfg_al = 6'h00;
    logic [LAT_W-1:0]  cfg_cl = 6'h06;
    logic              cfg_quarter = 1'b0;
    logic              cfg_lock = 1'b0;
    logic              req_vld = 1'b0;
    logic              req_wr = 1'b0;
    logic [ADDR_W-1:0] req_addr = '0;
    logic              req_rdy, wr_data_en, rd_phy, rd_data_vld, cfg_err;
    logic [LAT_W-1:0]  rd_lat_tot, ac_lat_tot;
    sls_mcmd_t         mem_cmd;
    int                n_errors = 0;
    int                num_checks = 0;
    logic [LAT_W-1:0]  al_tab [5] = '{6'h00, 6'h00, 6'h01, 6'h01, 6'h14};
    logic [LAT_W-1:0]  cl_tab [5] = '{6'h02, 6'h03, 6'h16, 6'h17, 6'h03};
    logic [4:0]        err_tab = 5'h09;

    always #5 clk = ~clk;

    sls_sched #(.TRCD(TRCD_TB)) i_dut (.clk(clk), .nrst(nrst), .ce(1'b1), .cfg_map(cfg_map),
        .cfg_al(cfg_al), .cfg_cl(cfg_cl), .cfg_quarter(cfg_quarter), .cfg_lock(cfg_lock),
        .req_vld(req_vld), .req_wr(req_wr), .req_addr(req_addr), .req_rdy(req_rdy),
        .mem_cmd(mem_cmd), .wr_data_en(wr_data_en), .rd_data_vld_phy(rd_phy),
        .rd_data_vld(rd_data_vld), .rd_lat_tot(rd_lat_tot), .ac_lat_tot(ac_lat_tot),
        .cfg_err(cfg_err));
    sls_mem_model i_mem (.clk(clk), .nrst(nrst), .mem_cmd(mem_cmd), .cfg_al(cfg_al),
        .cfg_cl(cfg_cl), .rd_data_vld_phy(rd_phy));

    // ----
    // Tasks
    // ----
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic tmo(input string what);
        n_errors++;
        $display("MISMATCH %s exp event seen timeout", what);
        final_report();
    endtask

    // Settings only change with the lock low
    task automatic set_cfg(input sls_map_t m, input logic q, input logic [LAT_W-1:0] al, cl);
        @(posedge clk);
        cfg_lock <= 1'b0;
        cfg_map <= m;
        cfg_quarter <= q;
        cfg_al <= al;
        cfg_cl <= cl;
        @(posedge clk);
        cfg_lock <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask

    function automatic sls_maddr_t map_of(input sls_map_t m, input logic [ADDR_W-1:0] a);
        sls_maddr_t r;
        r = a;
        case (m)
            SLS_MAP_CRBC: r = a;
            SLS_MAP_RCBC: begin
                r.bank = a[COL_W +: BANK_W];
                r.cs   = a[COL_W+BANK_W +: CS_W];
                r.row  = a[ADDR_W-1 -: ROW_W];
            end
            default: begin
                r.row  = a[COL_W +: ROW_W];
                r.bank = a[COL_W+ROW_W +: BANK_W];
                r.cs   = a[ADDR_W-1 -: CS_W];
            end
        endcase
        return r;
    endfunction

    task automatic do_req(input sls_map_t m, input logic wr, input logic [ADDR_W-1:0] a,
                          output int gap);
        int               t;
        int               ta;
        int               slot;
        logic [LAT_W-1:0] ac;
        ac = LAT_W'(PHY_AC_LAT + (cfg_quarter ? (wr ? CTL_AC_QTR_WR : CTL_AC_QTR_RD)
                                              : (wr ? CTL_AC_HALF_WR : CTL_AC_HALF_RD)));
        ta = -1;
        for (t = 0; req_rdy !== 1'b1; t++) begin
            if (t > 60) tmo("req_rdy");
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        req_vld <= 1'b1;
        req_wr <= wr;
        req_addr <= a;
        @(posedge clk);
        req_vld <= 1'b0;
        for (t = 0; t < 60; t++) begin
            #1;
            if (mem_cmd.vld === 1'b1 && mem_cmd.cmd === SLS_CMD_ACT) ta = t;
            if (mem_cmd.vld === 1'b1 && mem_cmd.cmd inside {SLS_CMD_RD, SLS_CMD_WR}) break;
            @(posedge clk);
        end
        if (t == 60) tmo("column");
        gap = (ta < 0) ? 0 : t - ta;
        `CHK("cmd", wr ? SLS_CMD_WR : SLS_CMD_RD, mem_cmd.cmd)
        `CHK("addr", map_of(m, a), mem_cmd.addr)
        for (t = 0; (wr ? wr_data_en : rd_data_vld) !== 1'b1; t++) begin
            if (t > 60) tmo("data slot");
            @(posedge clk);
            #1;
        end
        // Registered strobe lands one cycle after the halved latency
        slot = (int'(cfg_al) + int'(cfg_cl) - (wr ? 1 : 0)) / FR_PER_CORE + 1;
        `CHK("data slot", slot, t)
        `CHK("ac_lat_tot", ac, ac_lat_tot)
    endtask

    // ----
    // Sequence
    // ----
    initial begin
        int g;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            set_cfg(SLS_MAP_CBRC, 1'b0, al_tab[i], cl_tab[i]);
            `CHK("cfg_err", err_tab[i], cfg_err)
            `CHK("req_rdy", ~err_tab[i], req_rdy)
        end
        for (int m = 0; m < 3; m++) begin
            for (int q = 0; q < 2; q++) begin
                set_cfg(sls_map_t'(m), q[0], 6'h00, 6'h06);
                for (int k = 0; k < 5; k++) begin
                    do_req(sls_map_t'(m), k[0], ADDR_W'(k) << COL_W, g);
                end
                `CHK("rd_lat_tot", LAT_W'(PHY_RD_RET + (q ? 14 : 8)), rd_lat_tot)
            end
        end
        set_cfg(SLS_MAP_CRBC, 1'b0, 6'h06, 6'h06);
        do_req(SLS_MAP_CRBC, 1'b0, {1'b0, 14'h0005, 2'h1, 10'h000}, g);
        `CHK("act to col", 1, g)
        set_cfg(SLS_MAP_CRBC, 1'b0, 6'h00, 6'h06);
        do_req(SLS_MAP_CRBC, 1'b1, {1'b0, 14'h0006, 2'h2, 10'h000}, g);
        `CHK("early col", 1'b1, g >= TRCD_TB)
        set_cfg(SLS_MAP_CBRC, 1'b1, 6'h02, 6'h07);
        @(posedge clk);
        cfg_map <= SLS_MAP_RCBC;
        // Mapping must stay as locked
        do_req(SLS_MAP_CBRC, 1'b0, 27'h2A55A5A, g);
        final_report();
    end
endmodule
`default_nettype wire
